// *** pis_pkg.sv ***
// Purpose: Shared constants and types for the pulse induction sequencer
// Assumes: 50 MHz system clock
// Notes:   All phase times are in microseconds

package pis_pkg;

   // Clock and microsecond tick
   localparam int CLK_PERIOD_NS = 20;
   localparam int US_NS         = 1000;
   localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] TICK_LAST = 6'(CYC_PER_US - 1);

   // Phase lengths, microseconds
   localparam logic [10:0] DRIVE_US   = 11'd1500;
   localparam logic [10:0] SETTLE_US  = 11'd100;
   localparam logic [10:0] SAMPLE_US  = 11'd1200;
   localparam logic [10:0] PROC_US    = 11'd325;
   localparam int          CYCLE_US   = 3125;

   // Sampling grid
   localparam int          STEP_US    = 4;
   localparam logic [8:0]  N_SAMPLES  = 9'(1200 / STEP_US);
   localparam logic [4:0]  MEAN_N     = 5'd25;
   localparam int          WIN_US     = 100;

   // Window openings, microseconds after sampling starts, and first sample index
   localparam int          EARLY_US   = 130;
   localparam int          STD_US     = 300;
   localparam int          ZERO_US    = 1000;
   localparam logic [8:0]  EARLY_IDX  = 9'((EARLY_US + STEP_US - 1) / STEP_US);
   localparam logic [8:0]  STD_IDX    = 9'((STD_US + STEP_US - 1) / STEP_US);
   localparam logic [8:0]  ZERO_IDX   = 9'((ZERO_US + STEP_US - 1) / STEP_US);

   // Channels and long-term averaging
   localparam int          N_CHAN     = 4;
   localparam logic [2:0]  AVG_LAST   = 3'd7;

   typedef enum logic [2:0] {
      PIS_IDLE   = 3'b000,
      PIS_DRIVE  = 3'b001,
      PIS_SETTLE = 3'b010,
      PIS_SAMPLE = 3'b011,
      PIS_PROC   = 3'b100
   } pis_state_t;

   typedef struct packed {
      logic [1:0]  chan;
      logic [11:0] early;
      logic [11:0] standard;
      logic [11:0] zero;
   } pis_levels_t;

   typedef struct packed {
      logic [1:0]         chan;
      logic signed [12:0] early_sig;
      logic signed [12:0] std_sig;
   } pis_result_t;

endpackage

// *** pis_us_tick.sv ***
// Purpose: Free-running one-microsecond tick
// Assumes: CYC_PER_US clocks per microsecond
// Notes:   Tick is a one-cycle pulse

`timescale 1ns/10ps

module pis_us_tick (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   output logic      o_tick
);

   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   wire        wrap = (cnt_reg == pis_pkg::TICK_LAST);

   assign cnt_next = wrap ? 6'h00 : cnt_reg + 6'h01;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_reg <= 6'h00;
         o_tick  <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         o_tick  <= wrap;
      end
   end

endmodule // pis_us_tick

// *** pis_window_mean.sv ***
// Purpose: Accumulates one window of samples and divides by the window size
// Assumes: Start comes after the last add of the window
// Notes:   Division by repeated subtraction, result truncated

`timescale 1ns/10ps

module pis_window_mean (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_clear,
   input  wire logic        i_add,
   input  wire logic [11:0] i_sample,
   input  wire logic        i_start,
   output logic [11:0]      o_mean,
   output logic             o_valid
);

   logic [16:0] acc_reg;
   logic        busy_reg;
   wire         can_sub = (acc_reg >= 17'(pis_pkg::MEAN_N));

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         acc_reg  <= 17'h00000;
         busy_reg <= 1'b0;
         o_mean   <= 12'h000;
         o_valid  <= 1'b0;
      end
      else if (i_clear)
      begin
         acc_reg  <= 17'h00000;
         busy_reg <= 1'b0;
         o_mean   <= 12'h000;
         o_valid  <= 1'b0;
      end
      else if (i_add)
      begin
         acc_reg <= acc_reg + {5'h00, i_sample};
      end
      else if (i_start)
      begin
         busy_reg <= 1'b1;
         o_mean   <= 12'h000;
      end
      else if (busy_reg)
      begin
         if (can_sub)
         begin
            acc_reg <= acc_reg - 17'(pis_pkg::MEAN_N);
            o_mean  <= o_mean + 12'h001;
         end
         else
         begin
            busy_reg <= 1'b0;
            o_valid  <= 1'b1;
         end
      end
   end

endmodule // pis_window_mean

// *** pis_sequencer.sv ***
// Purpose: Drive, settle, sample and process sequencer for four coil channels
// Assumes: Converter raises done after each start and holds data until next start
// Notes:   Phase lengths are parameters so simulation can shorten them
//
// Operation
// - Each channel cycle opens with coil drive held 1500 us, then released.
// - Wait 100 us after drive release before sampling starts.
// - Sample 1200 us, 300 conversions every 4 us, stored in buffer.
// - Each stored result is 12 bits from the selected channel's converter.
// - Three averaging windows, each 100 us or 25 conversions.
// - Early window opens 130 us into sampling; its mean is the early level.
// - Standard window opens 300 us into sampling; mean is standard level.
// - Zero window opens 1000 us into sampling; mean is zero reference.
// - A 325 us processing slot follows sampling before next drive.
// - Channels run in fixed round-robin order, never overlapping.
// - Each channel cycle totals 3125 us; a channel repeats every four cycles.
// - Every eight cycles of the same channel average early, standard; subtract averaged zero reference.

`timescale 1ns/10ps

module pis_sequencer #(
   parameter logic [10:0] P_DRIVE_US  = pis_pkg::DRIVE_US,
   parameter logic [10:0] P_SETTLE_US = pis_pkg::SETTLE_US,
   parameter logic [10:0] P_SAMPLE_US = pis_pkg::SAMPLE_US,
   parameter logic [10:0] P_PROC_US   = pis_pkg::PROC_US
) (
   input  wire logic            i_clk,
   input  wire logic            i_nrst,
   input  wire logic            i_adc_done,
   input  wire logic [11:0]     i_adc_data,
   input  wire logic [8:0]      i_buf_addr,
   output logic [3:0]           o_coil_drive,
   output logic [1:0]           o_chan_sel,
   output logic                 o_conv_start,
   output logic [11:0]          o_buf_data,
   output logic                 o_levels_valid,
   output pis_pkg::pis_levels_t o_levels,
   output logic                 o_result_valid,
   output pis_pkg::pis_result_t o_result
);

   function automatic logic in_win(input logic [8:0] idx, input logic [8:0] first);
      in_win = (idx >= first) && (idx < first + 9'(pis_pkg::MEAN_N));
   endfunction

   function automatic logic signed [12:0] sig_of(input logic [14:0] tot_a, input logic [14:0] tot_z);
      logic signed [15:0] diff;
      diff   = $signed({1'b0, tot_a}) - $signed({1'b0, tot_z});
      sig_of = 13'(diff >>> 3);
   endfunction

   // Microsecond tick
   logic tick;

   pis_us_tick u_tick (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .o_tick (tick)
   );

   // Phase state
   pis_pkg::pis_state_t state_reg;
   pis_pkg::pis_state_t state_next;
   logic [10:0]         us_reg;
   logic [10:0]         us_next;
   logic [1:0]          chan_reg;
   logic [1:0]          chan_next;
   logic [10:0]         phase_len;

   always_comb
   begin
      case (state_reg)
         pis_pkg::PIS_DRIVE:  phase_len = P_DRIVE_US;
         pis_pkg::PIS_SETTLE: phase_len = P_SETTLE_US;
         pis_pkg::PIS_SAMPLE: phase_len = P_SAMPLE_US;
         pis_pkg::PIS_PROC:   phase_len = P_PROC_US;
         default:             phase_len = 11'h001;
      endcase
   end

   wire last_us = tick && (us_reg == phase_len - 11'h001);

   always_comb
   begin
      state_next = state_reg;
      chan_next  = chan_reg;
      us_next    = tick ? us_reg + 11'h001 : us_reg;
      case (state_reg)
         pis_pkg::PIS_IDLE:
         begin
            if (tick)
            begin
               state_next = pis_pkg::PIS_DRIVE;
               us_next    = 11'h000;
            end
         end
         pis_pkg::PIS_DRIVE, pis_pkg::PIS_SETTLE, pis_pkg::PIS_SAMPLE:
         begin
            if (last_us)
            begin
               state_next = pis_pkg::pis_state_t'(state_reg + 3'h1); // Codes run in phase order
               us_next    = 11'h000;
            end
         end
         pis_pkg::PIS_PROC:
         begin
            if (last_us)
            begin
               state_next = pis_pkg::PIS_DRIVE;
               chan_next  = chan_reg + 2'h1;
               us_next    = 11'h000;
            end
         end
         default:
         begin
            state_next = pis_pkg::PIS_IDLE;
            us_next    = 11'h000;
         end
      endcase
   end

   wire       drive_on   = (state_next == pis_pkg::PIS_DRIVE);
   wire [3:0] drive_next = drive_on ? (4'h1 << chan_next) : 4'h0;
   wire       conv_next  = tick && (state_next == pis_pkg::PIS_SAMPLE) && (us_next[1:0] == 2'b00);
   wire       samp_entry = (state_reg == pis_pkg::PIS_SETTLE) && (state_next == pis_pkg::PIS_SAMPLE);
   wire       proc_entry = (state_reg == pis_pkg::PIS_SAMPLE) && (state_next == pis_pkg::PIS_PROC);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_reg    <= pis_pkg::PIS_IDLE;
         us_reg       <= 11'h000;
         chan_reg     <= 2'h0;
         o_coil_drive <= 4'h0;
         o_chan_sel   <= 2'h0;
         o_conv_start <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         us_reg       <= us_next;
         chan_reg     <= chan_next;
         o_coil_drive <= drive_next;
         o_chan_sel   <= chan_next;
         o_conv_start <= conv_next;
      end
   end

   // Converter handshake synchronisers
   logic        done_s1;
   logic        done_s2;
   logic        done_s3;
   logic [11:0] data_s1;
   logic [11:0] data_s2;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
         data_s1 <= 12'h000;
         data_s2 <= 12'h000;
      end
      else
      begin
         done_s1 <= i_adc_done;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
         data_s1 <= i_adc_data;
         data_s2 <= data_s1;
      end
   end

   // Sample capture and buffer
   logic [8:0]  res_idx_reg;
   logic [11:0] buf_mem [0:299];

   wire res_ok = done_s2 && !done_s3 && (state_reg == pis_pkg::PIS_SAMPLE)
                 && (res_idx_reg < pis_pkg::N_SAMPLES);
   wire add_e  = res_ok && in_win(res_idx_reg, pis_pkg::EARLY_IDX);
   wire add_s  = res_ok && in_win(res_idx_reg, pis_pkg::STD_IDX);
   wire add_z  = res_ok && in_win(res_idx_reg, pis_pkg::ZERO_IDX);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         res_idx_reg <= 9'h000;
      end
      else if (samp_entry)
      begin
         res_idx_reg <= 9'h000;
      end
      else if (res_ok)
      begin
         res_idx_reg <= res_idx_reg + 9'h001;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (res_ok)
      begin
         buf_mem[res_idx_reg] <= data_s2;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_buf_data <= 12'h000;
      end
      else
      begin
         o_buf_data <= (i_buf_addr < pis_pkg::N_SAMPLES) ? buf_mem[i_buf_addr] : 12'h000;
      end
   end

   // Window means
   logic [11:0] mean_e;
   logic [11:0] mean_s;
   logic [11:0] mean_z;
   logic        val_e;
   logic        val_s;
   logic        val_z;

   pis_window_mean u_early (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_clear  (samp_entry),
      .i_add    (add_e),
      .i_sample (data_s2),
      .i_start  (proc_entry),
      .o_mean   (mean_e),
      .o_valid  (val_e)
   );

   pis_window_mean u_std (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_clear  (samp_entry),
      .i_add    (add_s),
      .i_sample (data_s2),
      .i_start  (proc_entry),
      .o_mean   (mean_s),
      .o_valid  (val_s)
   );

   pis_window_mean u_zero (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_clear  (samp_entry),
      .i_add    (add_z),
      .i_sample (data_s2),
      .i_start  (proc_entry),
      .o_mean   (mean_z),
      .o_valid  (val_z)
   );

   // Eight-cycle averaging per channel
   logic        pend_reg;
   logic [14:0] sum_e [0:3];
   logic [14:0] sum_s [0:3];
   logic [14:0] sum_z [0:3];
   logic [2:0]  cnt8  [0:3];

   wire         take   = pend_reg && val_e && val_s && val_z;
   wire [14:0]  tot_e  = sum_e[chan_reg] + {3'h0, mean_e};
   wire [14:0]  tot_s  = sum_s[chan_reg] + {3'h0, mean_s};
   wire [14:0]  tot_z  = sum_z[chan_reg] + {3'h0, mean_z};
   wire         eighth = (cnt8[chan_reg] == pis_pkg::AVG_LAST);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         pend_reg       <= 1'b0;
         o_levels_valid <= 1'b0;
         o_levels       <= '0;
         o_result_valid <= 1'b0;
         o_result       <= '0;
         for (int i = 0; i < pis_pkg::N_CHAN; i++)
         begin
            sum_e[i] <= 15'h0000;
            sum_s[i] <= 15'h0000;
            sum_z[i] <= 15'h0000;
            cnt8[i]  <= 3'h0;
         end
      end
      else
      begin
         o_levels_valid <= take;
         o_result_valid <= take && eighth;
         if (proc_entry)
         begin
            pend_reg <= 1'b1;
         end
         else if (take)
         begin
            pend_reg <= 1'b0;
         end
         if (take)
         begin
            o_levels <= '{chan: chan_reg, early: mean_e, standard: mean_s, zero: mean_z};
            if (eighth)
            begin
               o_result.chan      <= chan_reg;
               o_result.early_sig <= sig_of(tot_e, tot_z);
               o_result.std_sig   <= sig_of(tot_s, tot_z);
               sum_e[chan_reg]    <= 15'h0000;
               sum_s[chan_reg]    <= 15'h0000;
               sum_z[chan_reg]    <= 15'h0000;
               cnt8[chan_reg]     <= 3'h0;
            end
            else
            begin
               sum_e[chan_reg] <= tot_e;
               sum_s[chan_reg] <= tot_s;
               sum_z[chan_reg] <= tot_z;
               cnt8[chan_reg]  <= cnt8[chan_reg] + 3'h1;
            end
         end
      end
   end

endmodule // pis_sequencer

// *** pis_sequencer_chk_sva.sv ***
// Purpose: Port timing checks for the sequencer
// Assumes: One clock, async active-low reset
// Notes:   Counts in clock cycles
`timescale 1ns/10ps
module pis_sequencer_chk #(
   parameter logic [10:0] P_DRIVE_US  = pis_pkg::DRIVE_US,
   parameter logic [10:0] P_SETTLE_US = pis_pkg::SETTLE_US,
   parameter logic [10:0] P_SAMPLE_US = pis_pkg::SAMPLE_US,
   parameter logic [10:0] P_PROC_US   = pis_pkg::PROC_US
) (
   input wire logic                 i_clk,
   input wire logic                 i_nrst,
   input wire logic [3:0]           o_coil_drive,
   input wire logic [1:0]           o_chan_sel,
   input wire logic                 o_conv_start,
   input wire logic                 o_levels_valid,
   input wire pis_pkg::pis_levels_t o_levels,
   input wire logic                 o_result_valid,
   input wire pis_pkg::pis_result_t o_result
);
   localparam int CPU = pis_pkg::CYC_PER_US;
   localparam int DRV = int'(P_DRIVE_US) * CPU;
   localparam int SET = int'(P_SETTLE_US) * CPU;
   localparam int CYC = (int'(P_DRIVE_US) + int'(P_SETTLE_US) + int'(P_SAMPLE_US) + int'(P_PROC_US)) * CPU;
   localparam int PRC = int'(P_PROC_US) * CPU;
   logic drv_on, rise, fall;
   logic drv_d_reg, first_reg, seen_reg;
   int   drv_cnt_reg, gap_cnt_reg, cyc_cnt_reg, n_start_reg;
   assign drv_on = |o_coil_drive;
   assign rise   = drv_on & ~drv_d_reg;
   assign fall   = ~drv_on & drv_d_reg;
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         {drv_d_reg, first_reg, seen_reg} <= 3'h0;
         {drv_cnt_reg, gap_cnt_reg, cyc_cnt_reg, n_start_reg} <= '0;
      end
      else
      begin
         drv_d_reg   <= drv_on;
         seen_reg    <= seen_reg | rise;
         first_reg   <= fall | (first_reg & ~o_conv_start);
         drv_cnt_reg <= drv_on ? drv_cnt_reg + 1 : 0;
         gap_cnt_reg <= (fall | o_conv_start) ? 0 : gap_cnt_reg + 1;
         cyc_cnt_reg <= rise ? 0 : cyc_cnt_reg + 1;
         n_start_reg <= rise ? 0 : n_start_reg + int'(o_conv_start);
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_drive_width: assert property (fall |-> drv_cnt_reg == DRV)
      else $error("coil drive width wrong");
   a_settle_gap: assert property (o_conv_start && first_reg |-> gap_cnt_reg == SET - 1)
      else $error("settle gap wrong");
   a_start_pitch: assert property (o_conv_start && !first_reg |-> gap_cnt_reg == 199)
      else $error("conversion pitch wrong");
   a_start_count: assert property (rise && seen_reg |-> n_start_reg == 300)
      else $error("conversion count wrong");
   a_start_idle: assert property (drv_on |-> !o_conv_start)
      else $error("conversion during drive");
   a_drive_chan: assert property (drv_on |-> o_coil_drive == 4'h1 << o_chan_sel)
      else $error("drive bit not selected channel");
   a_cycle_len: assert property (rise && seen_reg |-> cyc_cnt_reg == CYC - 1)
      else $error("channel cycle length wrong");
   a_chan_next: assert property (rise && seen_reg |-> o_chan_sel == $past(o_chan_sel) + 2'h1)
      else $error("channel order wrong");
   a_sel_hold: assert property (!rise |-> $stable(o_chan_sel))
      else $error("channel changed mid cycle");
   a_levels_slot: assert property (o_levels_valid |-> !drv_on && n_start_reg == 300
      && o_levels.chan == o_chan_sel)
      else $error("levels outside processing slot");
   a_proc_slot: assert property (rise && seen_reg |-> gap_cnt_reg == PRC + 199)
      else $error("processing slot length wrong");
   a_result_pair: assert property (o_result_valid |-> o_levels_valid && o_result.chan == o_levels.chan)
      else $error("result without levels");
   c_levels: cover property (o_levels_valid);
   c_next_chan: cover property (rise && seen_reg);
   c_first_start: cover property (o_conv_start && first_reg);
endmodule // pis_sequencer_chk

// *** pis_adc_model.sv ***
// Purpose: Converter model answering conversion starts
// Assumes: Starts come at least 200 cycles apart
// Notes:   Glitch input sends a stray done
`timescale 1ns/10ps
module pis_adc_model (
   input  wire logic        i_clk,
   input  wire logic        i_start,
   input  wire logic        i_slow,
   input  wire logic        i_glitch,
   input  wire logic [11:0] i_base,
   output logic             o_done,
   output logic [11:0]      o_data
);
   int   k;
   int   w;
   logic g;
   initial
   begin
      o_done = 1'b0;
      o_data = 12'h000;
      k = 0;
      forever
      begin
         @(posedge i_clk);
         g = i_glitch;
         if (i_start || g)
         begin
            @(negedge i_clk);
            o_data = ~o_data;   // Old result no longer held
            w = i_slow ? $urandom_range(150, 20) : 0;
            repeat (w) @(negedge i_clk);
            if (!g)
            begin
               o_data = i_base + 12'(k * 7);
               k = (k + 1) % 300;
            end
            @(negedge i_clk);
            o_done = 1'b1;
            repeat (4) @(negedge i_clk);
            o_done = 1'b0;
         end
      end
   end
endmodule // pis_adc_model

// *** tb_pulse_induction_sequencer.sv ***
// Purpose: Self-checking bench for the sequencer
// Assumes: Shortened drive, settle and slot lengths
// Notes:   One full channel cycle plus next drive
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb_pulse_induction_sequencer;
   localparam logic [10:0] DRV_US = 11'h00a;
   localparam logic [10:0] SET_US = 11'h005;
   localparam logic [10:0] SMP_US = 11'h4b0;
   localparam logic [10:0] PRC_US = 11'h064;
   localparam int          CPU    = pis_pkg::CYC_PER_US;
   logic                 i_clk    = 1'b0;
   logic                 i_nrst   = 1'b0;
   logic                 slow     = 1'b0;
   logic                 glitch   = 1'b0;
   logic [11:0]          base     = 12'h000;
   logic [8:0]           buf_addr = 9'h000;
   logic                 adc_done, conv_start, levels_valid, result_valid;
   logic [11:0]          adc_data, buf_data;
   logic [3:0]           coil_drive;
   logic [1:0]           chan_sel;
   pis_pkg::pis_levels_t levels;
   pis_pkg::pis_result_t result;
   int                   bad_count = 0, n_compared = 0, cyc = 0, n, t0;
   always #10 i_clk = ~i_clk;
   always @(negedge i_clk) slow <= 1'($urandom_range(1, 0));
   pis_sequencer #(.P_DRIVE_US(DRV_US), .P_SETTLE_US(SET_US), .P_SAMPLE_US(SMP_US), .P_PROC_US(PRC_US)) dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_adc_done(adc_done), .i_adc_data(adc_data), .i_buf_addr(buf_addr),
      .o_coil_drive(coil_drive), .o_chan_sel(chan_sel), .o_conv_start(conv_start), .o_buf_data(buf_data),
      .o_levels_valid(levels_valid), .o_levels(levels), .o_result_valid(result_valid), .o_result(result));
   pis_adc_model adc (.i_clk(i_clk), .i_start(conv_start), .i_slow(slow), .i_glitch(glitch),
      .i_base(base), .o_done(adc_done), .o_data(adc_data));
   function automatic logic [11:0] smp(input int k);
      return base + 12'(k * 7);
   endfunction
   function automatic logic [11:0] mean(input int s);
      int acc;
      acc = 0;
      for (int k = s; k < s + 25; k++)
         acc += int'(smp(k));
      return 12'(acc / 25);
   endfunction
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         bad_count++;
         summarize();
      end
   end
   initial
   begin
      n = $urandom(79);
      base = 12'(12'hc00 + $urandom_range(255, 0));   // Wraps between standard and zero windows
      repeat (5) @(negedge i_clk);
      i_nrst = 1'b1;
      while (coil_drive === 4'h0) @(negedge i_clk);
      t0 = cyc;
      `CHK("first drive", 4'h1, coil_drive)
      `CHK("first channel", 2'h0, chan_sel)
      for (n = 0; coil_drive !== 4'h0; n++) @(negedge i_clk);
      `CHK("drive width", int'(DRV_US) * CPU, n)
      $display("test drive done");
      for (n = 0; conv_start !== 1'b1; n++) @(negedge i_clk);
      `CHK("settle gap", int'(SET_US) * CPU, n)
      $display("test settle done");
      for (n = 1; levels_valid !== 1'b1; n += int'(conv_start)) @(negedge i_clk);
      `CHK("conversions", 300, n)
      `CHK("levels channel", 2'h0, levels.chan)
      `CHK("early", mean((130 + 3) / 4), levels.early)
      `CHK("standard", mean(300 / 4), levels.standard)
      `CHK("zero", mean(1000 / 4), levels.zero)
      `CHK("result flag", 1'b0, result_valid)
      `CHK("result", 28'h0000000, result)
      $display("test levels done");
      glitch = 1'b1;
      @(negedge i_clk);
      glitch = 1'b0;
      repeat (200) @(negedge i_clk);
      for (int i = 0; i < 10; i++)
      begin
         buf_addr = (i == 0) ? 9'h000 : (i == 1) ? 9'h12b : (i == 2) ? 9'h12c : (i == 3) ? 9'h1ff
            : 9'($urandom_range(299, 0));
         @(negedge i_clk);
         `CHK("buffer", buf_addr < 9'h12c ? smp(int'(buf_addr)) : 12'h000, buf_data)
      end
      $display("test buffer done");
      while (coil_drive === 4'h0) @(negedge i_clk);
      `CHK("next drive", 4'h2, coil_drive)
      `CHK("next channel", 2'h1, chan_sel)
      `CHK("cycle length", (int'(DRV_US) + int'(SET_US) + int'(SMP_US) + int'(PRC_US)) * CPU, cyc - t0)
      $display("test next channel done");
      summarize();
   end
endmodule // tb_pulse_induction_sequencer
bind pis_sequencer pis_sequencer_chk #(.P_DRIVE_US(P_DRIVE_US), .P_SETTLE_US(P_SETTLE_US),
   .P_SAMPLE_US(P_SAMPLE_US), .P_PROC_US(P_PROC_US)) u_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .o_coil_drive(o_coil_drive), .o_chan_sel(o_chan_sel),
   .o_conv_start(o_conv_start), .o_levels_valid(o_levels_valid), .o_levels(o_levels),
   .o_result_valid(o_result_valid), .o_result(o_result));
